// File: src/dogp_pkg.sv
// Register map, field positions and reset values for the dual octal GPIO block
package dogp_pkg;
  localparam int unsigned DOGP_AW = 4;
  localparam int unsigned DOGP_DW = 8;
  localparam logic [3:0] DOGP_H_LEVEL = 4'h0;
  localparam logic [3:0] DOGP_H_LATCH = 4'h1;
  localparam logic [3:0] DOGP_H_DIR = 4'h2;
  localparam logic [3:0] DOGP_SEG_40_47 = 4'h3;
  localparam logic [3:0] DOGP_J_LEVEL = 4'h4;
  localparam logic [3:0] DOGP_J_LATCH = 4'h5;
  localparam logic [3:0] DOGP_J_DIR = 4'h6;
  localparam logic [3:0] DOGP_SEG_32_39 = 4'h7;
  localparam logic [3:0] DOGP_G_LEVEL = 4'h8;
  localparam int unsigned DOGP_PU_BIT = 5;
  localparam logic [7:0] DOGP_DIR_RST = 8'hFF;
  localparam logic [7:0] DOGP_LAT_RST = 8'h00;
  localparam logic [7:0] DOGP_SEG_RST = 8'h00;
  // Pull-up control: set = pull-ups on, clear = off; reset leaves them off
  localparam logic DOGP_PU_RST = 1'b0;
  // Bank J pin 0 has no segment function
  localparam logic [7:0] DOGP_J_SEG_MASK = 8'hFE;
endpackage : dogp_pkg

// File: src/dogp_sync.sv
// Two-flop synchroniser for a bank of pin inputs
module dogp_sync
  import dogp_pkg::*;
#(
  parameter int unsigned W = 8
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : dogp_sync

// File: src/dogp_top.sv
// Two octal GPIO banks with LCD segment override and bank J pull-ups
// What this block does
// - Bank H: eight pins, level, latch, direction.
// - Direction 0 drives latch; 1 reads pin.
// - Each pin's direction bit acts alone.
// - Segment enable blocks drive and input use.
// - H pins map to segments 47..44, 40..43.
// - Segment ownership ignores the direction bit.
// - Bank J: same scheme as bank H.
// - Bank J pins reset as inputs.
// - J pins 1..7 overridable; pin 0 never.
// - J pins map 33..35, then 39..36.
// - One shared bit gates J pull-ups.
// - Output direction disables a pin's pull-up.
// - Pull-ups disabled after every reset.
// - Parameter removes both banks for small package.
// - Overrides never written into direction register.
// - Small package: pull-up bit reads zero.
//
// Added by the designer: the register addresses and the plain strobed port.
module dogp_top
  import dogp_pkg::*;
#(
  parameter bit HAS_BANKS = 1'b1,
  parameter int unsigned WIDTH = 8
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [7:0] bank_h_pin_in,
  output logic [7:0] bank_h_pin_out,
  output logic [7:0] bank_h_pin_oe,
  output logic [7:0] lcd_h_seg_own,
  input wire logic [7:0] bank_j_pin_in,
  output logic [7:0] bank_j_pin_out,
  output logic [7:0] bank_j_pin_oe,
  output logic [7:0] lcd_j_seg_own,
  output logic [7:0] bank_j_pullup_on
);
  // Remaps and masks below are written for eight-bit banks only
  if (WIDTH != DOGP_DW)
  begin : g_bad_width
    $error("dogp_top supports only 8-bit banks");
  end

  // Segment register bit i -> pin index, remapped per bank
  function automatic logic [7:0] map_h(input logic [7:0] se);
    map_h = {se[3], se[2], se[1], se[0], se[4], se[5], se[6], se[7]};
  endfunction : map_h

  function automatic logic [7:0] map_j(input logic [7:0] se);
    map_j = {se[4], se[5], se[6], se[7], se[3], se[2], se[1], 1'b0};
  endfunction : map_j

  // Drive only where software asks for output and no segment owns the pin
  function automatic logic [7:0] drive_of(input logic [7:0] dir, input logic [7:0] own);
    drive_of = ~dir & ~own;
  endfunction : drive_of

  logic [7:0] h_lat_r, h_dir_r, seg5_r, j_lat_r, j_dir_r, seg4_r;
  logic [7:0] h_lat_nxt, h_dir_nxt, seg5_nxt, j_lat_nxt, j_dir_nxt, seg4_nxt;
  logic pu_ctl_r, pu_ctl_nxt;
  logic [7:0] h_sync, j_sync;
  logic [7:0] rdata_nxt;

  dogp_sync #(.W(8)) u_sync_h (
    .clk(clk), .rst_b(rst_b), .ce(ce), .d(bank_h_pin_in), .q(h_sync)
  );
  dogp_sync #(.W(8)) u_sync_j (
    .clk(clk), .rst_b(rst_b), .ce(ce), .d(bank_j_pin_in), .q(j_sync)
  );

  wire en = HAS_BANKS;
  wire wr_h_lat = en && wr && (addr == DOGP_H_LEVEL || addr == DOGP_H_LATCH);
  wire wr_j_lat = en && wr && (addr == DOGP_J_LEVEL || addr == DOGP_J_LATCH);
  wire wr_h_dir = en && wr && addr == DOGP_H_DIR;
  wire wr_j_dir = en && wr && addr == DOGP_J_DIR;
  wire wr_seg5 = en && wr && addr == DOGP_SEG_40_47;
  wire wr_seg4 = en && wr && addr == DOGP_SEG_32_39;
  wire wr_g = en && wr && addr == DOGP_G_LEVEL;

  assign h_lat_nxt = wr_h_lat ? wdata : h_lat_r;
  assign j_lat_nxt = wr_j_lat ? wdata : j_lat_r;
  // Only software writes reach direction; overrides act on pins only
  assign h_dir_nxt = wr_h_dir ? wdata : h_dir_r;
  assign j_dir_nxt = wr_j_dir ? wdata : j_dir_r;
  assign seg5_nxt = wr_seg5 ? wdata : seg5_r;
  assign seg4_nxt = wr_seg4 ? wdata : seg4_r;
  assign pu_ctl_nxt = wr_g ? wdata[DOGP_PU_BIT] : pu_ctl_r;

  wire [7:0] h_own = en ? map_h(seg5_r) : 8'h00;
  wire [7:0] j_own = en ? (map_j(seg4_r) & DOGP_J_SEG_MASK) : 8'h00;
  // Per-bit drive; segment owner wins over direction
  wire [7:0] h_oe_nxt = en ? drive_of(h_dir_r, h_own) : 8'h00;
  wire [7:0] j_oe_nxt = en ? drive_of(j_dir_r, j_own) : 8'h00;
  // Pull-up active only when bit set, pin input and not a segment
  wire [7:0] j_pu_nxt = (en && pu_ctl_r) ? (j_dir_r & ~j_own) : 8'h00;
  // Segment pins read as zero: input use suppressed
  wire [7:0] h_in = h_sync & ~h_own;
  wire [7:0] j_in = j_sync & ~j_own;

  always_comb
  begin
    rdata_nxt = 8'h00;
    if (rd && en)
    begin
      case (addr)
        DOGP_H_LEVEL: rdata_nxt = h_in;
        DOGP_H_LATCH: rdata_nxt = h_lat_r;
        DOGP_H_DIR: rdata_nxt = h_dir_r;
        DOGP_SEG_40_47: rdata_nxt = seg5_r;
        DOGP_J_LEVEL: rdata_nxt = j_in;
        DOGP_J_LATCH: rdata_nxt = j_lat_r;
        DOGP_J_DIR: rdata_nxt = j_dir_r;
        DOGP_SEG_32_39: rdata_nxt = seg4_r;
        DOGP_G_LEVEL: rdata_nxt = 8'(pu_ctl_r) << DOGP_PU_BIT;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      h_lat_r <= DOGP_LAT_RST;
      j_lat_r <= DOGP_LAT_RST;
      h_dir_r <= DOGP_DIR_RST;
      j_dir_r <= DOGP_DIR_RST;
      seg5_r <= DOGP_SEG_RST;
      seg4_r <= DOGP_SEG_RST;
      pu_ctl_r <= DOGP_PU_RST;
      rdata <= 8'h00;
      bank_h_pin_out <= 8'h00;
      bank_h_pin_oe <= 8'h00;
      lcd_h_seg_own <= 8'h00;
      bank_j_pin_out <= 8'h00;
      bank_j_pin_oe <= 8'h00;
      lcd_j_seg_own <= 8'h00;
      bank_j_pullup_on <= 8'h00;
    end
    else if (ce)
    begin
      h_lat_r <= h_lat_nxt;
      j_lat_r <= j_lat_nxt;
      h_dir_r <= h_dir_nxt;
      j_dir_r <= j_dir_nxt;
      seg5_r <= seg5_nxt;
      seg4_r <= seg4_nxt;
      pu_ctl_r <= pu_ctl_nxt;
      rdata <= rdata_nxt;
      bank_h_pin_out <= h_lat_r & h_oe_nxt;
      bank_h_pin_oe <= h_oe_nxt;
      lcd_h_seg_own <= h_own;
      bank_j_pin_out <= j_lat_r & j_oe_nxt;
      bank_j_pin_oe <= j_oe_nxt;
      lcd_j_seg_own <= j_own;
      bank_j_pullup_on <= j_pu_nxt;
    end
  end

  property p_h_seg_blocks;
    @(posedge clk) disable iff (!rst_b)
      ce && en && seg5_r[7] |=> !bank_h_pin_oe[0] && lcd_h_seg_own[0];
  endproperty
  a_h_seg_blocks: assert property (p_h_seg_blocks) else $error("lcd_segment_47_out pin driven");

  property p_h_drive;
    @(posedge clk) disable iff (!rst_b)
      ce && en && !h_dir_r[4] && !seg5_r[0] |=>
        bank_h_pin_oe[4] && bank_h_pin_out[4] == $past(h_lat_r[4]);
  endproperty
  a_h_drive: assert property (p_h_drive) else $error("bank h pin 4 not driven");

  property p_j0_never_seg;
    @(posedge clk) disable iff (!rst_b) !lcd_j_seg_own[0];
  endproperty
  a_j0_never_seg: assert property (p_j0_never_seg) else $error("j pin0 owned");

  property p_j_lcd_segment_33_out;
    @(posedge clk) disable iff (!rst_b)
      ce && en && seg4_r[1] |=> lcd_j_seg_own[1] && !bank_j_pin_oe[1];
  endproperty
  a_j_lcd_segment_33_out: assert property (p_j_lcd_segment_33_out) else $error("lcd_segment_33_out map wrong");

  property p_pu_out_off;
    @(posedge clk) disable iff (!rst_b)
      ce && !j_dir_r[4] |=> !bank_j_pullup_on[4];
  endproperty
  a_pu_out_off: assert property (p_pu_out_off) else $error("pull-up on output");

  sequence s_rst_rel;
    !rst_b ##1 rst_b;
  endsequence
  property p_reset_state;
    @(posedge clk) s_rst_rel |-> bank_j_pullup_on == 8'h00 && j_dir_r == DOGP_DIR_RST;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state");

  property p_lat_write;
    @(posedge clk) disable iff (!rst_b)
      ce && en && wr && addr == DOGP_H_LEVEL |=> h_lat_r == $past(wdata);
  endproperty
  a_lat_write: assert property (p_lat_write) else $error("level write missed latch");

  sequence s_rd_lat;
    ce && en && rd && addr == DOGP_J_LATCH;
  endsequence
  property p_lat_read;
    @(posedge clk) disable iff (!rst_b) s_rd_lat |=> rdata == $past(j_lat_r);
  endproperty
  a_lat_read: assert property (p_lat_read) else $error("latch read wrong");

  property p_dir_keep;
    @(posedge clk) disable iff (!rst_b)
      ce && !(wr && addr == DOGP_J_DIR) |=> j_dir_r == $past(j_dir_r);
  endproperty
  a_dir_keep: assert property (p_dir_keep) else $error("direction changed");

  // Pin checks look one edge after the registers they depend on
  property p_h_seg40;
    @(posedge clk) disable iff (!rst_b)
      ce && en && seg5_r[0] |=> lcd_h_seg_own[4];
  endproperty
  a_h_seg40: assert property (p_h_seg40) else $error("seg40 not on pin 4");

  property p_h_per_pin;
    @(posedge clk) disable iff (!rst_b)
      ce && en && h_dir_r[0] && !h_dir_r[4] && !seg5_r[0] |=> !bank_h_pin_oe[0] && bank_h_pin_oe[4];
  endproperty
  a_h_per_pin: assert property (p_h_per_pin) else $error("pin directions coupled");

  property p_h_seg_dir;
    @(posedge clk) disable iff (!rst_b)
      ce && en && seg5_r[0] && !h_dir_r[4] |=> !bank_h_pin_oe[4] && !bank_h_pin_out[4];
  endproperty
  a_h_seg_dir: assert property (p_h_seg_dir) else $error("segment pin still driven");

  property p_h_level_mask;
    @(posedge clk) disable iff (!rst_b)
      ce && en && rd && addr == DOGP_H_LEVEL && seg5_r[0] |=> !rdata[4];
  endproperty
  a_h_level_mask: assert property (p_h_level_mask) else $error("segment pin read");

  property p_j_drive;
    @(posedge clk) disable iff (!rst_b)
      ce && en && !j_dir_r[4] && !seg4_r[7] |=>
        bank_j_pin_oe[4] && bank_j_pin_out[4] == $past(j_lat_r[4]);
  endproperty
  a_j_drive: assert property (p_j_drive) else $error("bank j pin 4 not driven");

  property p_j_seg36;
    @(posedge clk) disable iff (!rst_b)
      ce && en && seg4_r[4] |=> lcd_j_seg_own[7] && !bank_j_pin_oe[7] && !bank_j_pullup_on[7];
  endproperty
  a_j_seg36: assert property (p_j_seg36) else $error("seg36 pin not taken");

  property p_j_level_mask;
    @(posedge clk) disable iff (!rst_b)
      ce && en && rd && addr == DOGP_J_LEVEL && seg4_r[1] |=> !rdata[1];
  endproperty
  a_j_level_mask: assert property (p_j_level_mask) else $error("j segment pin read");

  property p_pu_on;
    @(posedge clk) disable iff (!rst_b)
      ce && en && pu_ctl_r && j_dir_r[0] |=> bank_j_pullup_on[0];
  endproperty
  a_pu_on: assert property (p_pu_on) else $error("pull-up missing");

  property p_pu_ctl_off;
    @(posedge clk) disable iff (!rst_b)
      ce && !pu_ctl_r |=> bank_j_pullup_on == 8'h00;
  endproperty
  a_pu_ctl_off: assert property (p_pu_ctl_off) else $error("pull-up on while off");

  property p_h_dir_keep;
    @(posedge clk) disable iff (!rst_b)
      ce && !(wr && addr == DOGP_H_DIR) |=> h_dir_r == $past(h_dir_r);
  endproperty
  a_h_dir_keep: assert property (p_h_dir_keep) else $error("h direction changed");

  sequence s_rd_g;
    ce && en && rd && addr == DOGP_G_LEVEL;
  endsequence
  property p_g_read;
    @(posedge clk) disable iff (!rst_b) s_rd_g |=> rdata[DOGP_PU_BIT] == $past(pu_ctl_r);
  endproperty
  a_g_read: assert property (p_g_read) else $error("pull-up bit read wrong");

  sequence s_j_out_wr;
    ce && en && wr && addr == DOGP_J_DIR && !wdata[5] && !seg4_r[6];
  endsequence
  sequence s_ce_on;
    ce && en;
  endsequence
  property p_j_dir_to_pin;
    @(posedge clk) disable iff (!rst_b)
      s_j_out_wr ##1 s_ce_on |=> bank_j_pin_oe[5];
  endproperty
  a_j_dir_to_pin: assert property (p_j_dir_to_pin) else $error("dir write not on pin");
endmodule : dogp_top

// File: sim/dogp_pins.sv
// Pad model: block drive wins, then the weak pull-up, then the outside level
module dogp_pins
(
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pull_on,
  input wire logic [7:0] ext,
  output logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Outside level only counts where nothing stronger holds the pin
  assign pin_in = (pin_out & pin_oe) | (~pin_oe & pull_on) | (~pin_oe & ~pull_on & ext);
endmodule : dogp_pins

// File: sim/dogp_top_tb.sv
// Self-checking bench for the dual octal GPIO block
module dogp_top_tb;
  import dogp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, ce, wr, rd;
  logic [7:0] s_rdata, s_oe, s_pu;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, h_in, h_out, h_oe, h_own, h_ext;
  logic [7:0] j_in, j_out, j_oe, j_own, j_pu, j_ext;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  // Small package variant: no banks, every read zero
  dogp_top #(.HAS_BANKS(1'b0)) u_small (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(s_rdata), .bank_h_pin_in(8'h00),
    .bank_h_pin_out(), .bank_h_pin_oe(s_oe), .lcd_h_seg_own(), .bank_j_pin_in(8'h00),
    .bank_j_pin_out(), .bank_j_pin_oe(), .lcd_j_seg_own(), .bank_j_pullup_on(s_pu));
  dogp_top u_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .bank_h_pin_in(h_in), .bank_h_pin_out(h_out),
    .bank_h_pin_oe(h_oe), .lcd_h_seg_own(h_own), .bank_j_pin_in(j_in),
    .bank_j_pin_out(j_out), .bank_j_pin_oe(j_oe), .lcd_j_seg_own(j_own),
    .bank_j_pullup_on(j_pu));
  dogp_pins u_hpad (.pin_out(h_out), .pin_oe(h_oe), .pull_on(8'h00), .ext(h_ext), .pin_in(h_in));
  dogp_pins u_jpad (.pin_out(j_out), .pin_oe(j_oe), .pull_on(j_pu), .ext(j_ext), .pin_in(j_in));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // Ceiling well above the roughly 170 cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: timeout", $time);
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp, what);
  endtask : rd_chk
  // Covers register-to-pin latency plus the input synchroniser
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask : settle
  task automatic t_reset;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk(j_pu, 8'h00, "pull-ups");
    chk(h_oe | j_oe, 8'h00, "drive");
    rd_chk(DOGP_J_DIR, DOGP_DIR_RST, "J dir");
    rd_chk(DOGP_G_LEVEL, 8'h00, "G reg");
    wr_reg(4'hF, 8'hFF);
    rd_chk(4'hF, 8'h00, "unmapped");
    $display("test reset done");
  endtask : t_reset
  task automatic t_bank_h;
    h_ext <= 8'h3C;
    wr_reg(DOGP_H_LATCH, 8'hA5);
    wr_reg(DOGP_H_DIR, 8'h0F);
    settle();
    chk(h_oe, 8'hF0, "H oe");
    chk(h_out, 8'hA0, "H out");
    rd_chk(DOGP_H_LEVEL, 8'hAC, "H level");
    rd_chk(DOGP_H_LATCH, 8'hA5, "H latch");
    wr_reg(DOGP_H_LEVEL, 8'h5A);
    wr_reg(DOGP_SEG_40_47, 8'h81);
    settle();
    chk(h_own, 8'h11, "H own");
    chk(h_oe, 8'hE0, "H oe seg");
    chk(h_out, 8'h40, "H out seg");
    rd_chk(DOGP_H_DIR, 8'h0F, "H dir kept");
    rd_chk(DOGP_H_LEVEL, 8'h4C, "H level seg");
    rd_chk(DOGP_H_LATCH, 8'h5A, "H latch");
    $display("test bank H done");
  endtask : t_bank_h
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(DOGP_H_LATCH, 8'hFF);
    ce <= 1'b1;
    rd_chk(DOGP_H_LATCH, 8'h5A, "frozen latch");
    $display("test clock enable done");
  endtask : t_freeze
  task automatic t_small;
    wr_reg(DOGP_G_LEVEL, 8'hFF);
    wr_reg(DOGP_H_DIR, 8'h00);
    settle();
    chk(s_oe, 8'h00, "small drive");
    chk(s_pu, 8'h00, "small pull-ups");
    rd_chk(DOGP_G_LEVEL, 8'h20, "G reg set");
    chk(s_rdata, 8'h00, "small G");
    $display("test small package done");
  endtask : t_small
  task automatic t_seg_map;
    logic [7:0] eh, ej;
    for (int i = 0; i < 8; i++)
    begin
      eh = 8'h01 << ((i < 4) ? i + 4 : 7 - i);
      ej = (i == 0) ? 8'h00 : 8'h01 << ((i < 4) ? i : 11 - i);
      wr_reg(DOGP_SEG_40_47, 8'h01 << i);
      wr_reg(DOGP_SEG_32_39, 8'h01 << i);
      settle();
      chk(h_own, eh, "H map");
      chk(j_own, ej, "J map");
    end
    wr_reg(DOGP_SEG_40_47, 8'h00);
    wr_reg(DOGP_SEG_32_39, 8'h00);
    $display("test segment map done");
  endtask : t_seg_map
  task automatic t_bank_j;
    j_ext <= 8'h00;
    wr_reg(DOGP_J_LATCH, 8'h33);
    wr_reg(DOGP_J_DIR, 8'h0F);
    settle();
    chk(j_pu, 8'h00, "pu off");
    rd_chk(DOGP_J_LEVEL, 8'h30, "J level");
    rd_chk(DOGP_J_LATCH, 8'h33, "J latch");
    wr_reg(DOGP_G_LEVEL, 8'h20);
    settle();
    chk(j_pu, 8'h0F, "pu inputs");
    rd_chk(DOGP_J_LEVEL, 8'h3F, "J level pu");
    wr_reg(DOGP_SEG_32_39, 8'h03);
    settle();
    chk(j_own, 8'h02, "J own");
    chk(j_pu, 8'h0D, "pu seg");
    rd_chk(DOGP_J_LEVEL, 8'h3D, "J level seg");
    $display("test bank J done");
  endtask : t_bank_j
  initial
  begin
    rst_b = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    h_ext = 8'h00;
    j_ext = 8'h00;
    t_reset();
    t_bank_h();
    t_freeze();
    t_seg_map();
    t_bank_j();
    t_small();
    t_reset();
    stop_test();
  end
endmodule : dogp_top_tb
